// ### rtl/dadc_pkg.sv
/*
  Shared constants, types and helpers for the dual converter output stage.
  Assumes a single system clock and an asynchronous active-low reset.
*/
package dadc_pkg;

  // word width and pipeline length of each channel
  localparam int unsigned WORD_W = 8;
  localparam int unsigned PIPE_DEPTH = 4;

  // sample-clock edges that must pass after standby before data is good
  localparam logic [3:0] RECOVERY_CYCLES = 4'hF;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam logic [7:0] WORD_RESET = 8'h00;

  // strap codes, first strap in the upper bit
  localparam logic [1:0] STRAP_STBY_BOTH = 2'h0;
  localparam logic [1:0] STRAP_STBY_B = 2'h1;
  localparam logic [1:0] STRAP_NORMAL = 2'h2;
  localparam logic [1:0] STRAP_ALIGN = 2'h3;

  typedef enum logic [3:0] {
    MODE_STBY_BOTH = 4'h1,
    MODE_STBY_B = 4'h2,
    MODE_NORMAL = 4'h4,
    MODE_ALIGN = 4'h8
  } dadc_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RECOVER = 3'h2,
    ST_RUN = 3'h4
  } dadc_state_t;

  // strap decode; every code is legal
  function automatic dadc_mode_t dadc_decode(input logic [1:0] straps);
    dadc_mode_t m;
    unique case (straps)
      STRAP_STBY_BOTH: m = MODE_STBY_BOTH;
      STRAP_STBY_B: m = MODE_STBY_B;
      STRAP_NORMAL: m = MODE_NORMAL;
      STRAP_ALIGN: m = MODE_ALIGN;
    endcase
    return m;
  endfunction : dadc_decode

  // raw result is offset binary; twos complement flips the sign bit
  function automatic logic [7:0] dadc_code(input logic [7:0] raw, input logic twos);
    return twos ? {~raw[7], raw[6:0]} : raw;
  endfunction : dadc_code

  // channel power state walk
  function automatic dadc_state_t dadc_next_state(input dadc_state_t st, input logic stby,
                                                  input logic rise, input logic [3:0] cnt);
    dadc_state_t n;
    unique case (st)
      ST_IDLE: n = stby ? ST_IDLE : ST_RECOVER;
      ST_RECOVER: begin
        if (stby) n = ST_IDLE;
        else if (rise && cnt == RECOVERY_CYCLES - CNT_STEP) n = ST_RUN;
        else n = ST_RECOVER;
      end
      ST_RUN: n = stby ? ST_IDLE : ST_RUN;
      default: n = ST_IDLE;
    endcase
    return n;
  endfunction : dadc_next_state

  // recovery edge count, held at zero outside recovery
  function automatic logic [3:0] dadc_next_count(input dadc_state_t st, input logic stby,
                                                 input logic rise, input logic [3:0] cnt);
    if (st != ST_RECOVER || stby) return CNT_RESET;
    return rise ? cnt + CNT_STEP : cnt;
  endfunction : dadc_next_count

endpackage : dadc_pkg

// ### rtl/dadc_chan.sv
/*
  One converter channel: sample-clock edge detect, result pipeline and
  output word register with optional half-period skew.
  Assumes the sample clock level is synchronous to the system clock.
*/
`timescale 1ns/100ps
module dadc_chan import dadc_pkg::*; (
  input wire logic i_clk_sys, // system clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic i_enc, // sample clock level
  input wire logic i_enable, // channel out of standby
  input wire logic i_half, // skew output by half a period
  input wire logic i_twos, // twos complement coding
  input wire logic [WORD_W-1:0] i_conv, // raw result, offset binary
  output logic o_rise, // accepted rising sample edge
  output logic [WORD_W-1:0] o_word // registered output word
);

  logic enc_q;
  logic enc_d;
  logic fall;
  logic [WORD_W-1:0] pipe_q [PIPE_DEPTH];
  logic [WORD_W-1:0] pipe_d [PIPE_DEPTH];
  logic [WORD_W-1:0] stage_q;
  logic [WORD_W-1:0] stage_d;
  logic [WORD_W-1:0] word_q;
  logic [WORD_W-1:0] word_d;

  // edges are ignored in standby: the clock input is off
  always_comb begin
    enc_d = i_enc;
    o_rise = i_enable && i_enc && !enc_q;
    fall = i_enable && !i_enc && enc_q;
    pipe_d = pipe_q;
    stage_d = stage_q;
    word_d = word_q;
    if (o_rise) begin
      pipe_d[0] = i_conv;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_d[i] = pipe_q[i-1];
      end
      stage_d = pipe_q[PIPE_DEPTH-1];
      if (!i_half) begin
        word_d = dadc_code(pipe_q[PIPE_DEPTH-1], i_twos);
      end
    end
    // skewed word waits for the falling edge, half a period later
    if (fall && i_half) begin
      word_d = dadc_code(stage_q, i_twos);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      enc_q <= 1'b0;
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_q[i] <= WORD_RESET;
      end
      stage_q <= WORD_RESET;
      word_q <= WORD_RESET;
    end else begin
      enc_q <= enc_d;
      pipe_q <= pipe_d;
      stage_q <= stage_d;
      word_q <= word_d;
    end
  end

  assign o_word = word_q;

  // helper history of accepted samples for the checks below
  logic [31:0] hist_q;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hist_q <= 32'h0000_0000;
    end else if (o_rise) begin
      hist_q <= {hist_q[23:0], i_conv};
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  property p_latency;
    o_rise && !i_half |=> o_word[6:0] == $past(hist_q[30:24]);
  endproperty
  a_latency: assert property (p_latency) else $error("word is not the sample four edges old");

  property p_format;
    o_rise && !i_half |=> o_word[7] == ($past(hist_q[31]) ^ $past(i_twos));
  endproperty
  a_format: assert property (p_format) else $error("sign bit coding wrong");

  property p_edge_normal;
    $changed(o_word) && !$past(i_half) |-> $past(o_rise);
  endproperty
  a_edge_normal: assert property (p_edge_normal) else $error("word moved off rising edge");

  property p_edge_half;
    $changed(o_word) && $past(i_half) |-> $past(fall);
  endproperty
  a_edge_half: assert property (p_edge_half) else $error("skewed word moved off falling edge");

endmodule : dadc_chan

// ### rtl/dadc_top.sv
/*
  Digital control and output stage of a dual 8-bit sampling converter:
  strap decode, per-channel standby and recovery, output drivers.
  Assumes sample clocks and straps are synchronous to the system clock
  and that the analog core presents each raw result in offset binary.
*/

// Summary of operation
// - output word lags sample by four edges
// - output word updates on channel rising edge
// - standby channel outputs are high impedance
// - format strap high gives twos complement
// - data valid after fifteen edges from standby
// - standby both channels or only channel b
// - standby also turns sample-clock inputs off
// - align mode adds half period to b
// - antiphase clocks align: b ready on a rising
// - shared clock align: b in antiphase
// - shared clock normal: both same edge
// - 00 both, 01 b, 10 normal, 11 align
// - two 8-bit words, two sample clocks
`timescale 1ns/100ps
module dadc_top import dadc_pkg::*; (
  input wire logic i_clk_sys, // system clock, 10 MHz
  input wire logic i_arst_n, // async reset, active low
  input wire logic i_sample_clock_chan_a, // channel a sample clock
  input wire logic i_sample_clock_chan_b, // channel b sample clock
  input wire logic i_mode_select_first, // mode strap, upper bit
  input wire logic i_mode_select_second, // mode strap, lower bit
  input wire logic i_output_format_select, // high: twos complement
  input wire logic [WORD_W-1:0] i_conv_result_chan_a, // raw result a
  input wire logic [WORD_W-1:0] i_conv_result_chan_b, // raw result b
  output logic [WORD_W-1:0] o_sample_word_chan_a, // output word a
  output logic o_sample_word_oe_chan_a, // word a driven
  output logic [WORD_W-1:0] o_sample_word_chan_b, // output word b
  output logic o_sample_word_oe_chan_b, // word b driven
  output logic o_clock_in_en_chan_a, // sample clock a input on
  output logic o_clock_in_en_chan_b, // sample clock b input on
  output logic o_data_valid_chan_a, // a past recovery
  output logic o_data_valid_chan_b // b past recovery
);

  // strap and format registers
  dadc_mode_t mode_q;
  dadc_mode_t mode_d;
  logic twos_q;
  logic twos_d;

  // channel a power state
  dadc_state_t st_a_q;
  dadc_state_t st_a_d;
  logic [3:0] cnt_a_q;
  logic [3:0] cnt_a_d;
  logic en_a_q;
  logic en_a_d;
  logic valid_a_q;
  logic valid_a_d;

  // channel b power state
  dadc_state_t st_b_q;
  dadc_state_t st_b_d;
  logic [3:0] cnt_b_q;
  logic [3:0] cnt_b_d;
  logic en_b_q;
  logic en_b_d;
  logic valid_b_q;
  logic valid_b_d;

  // decoded mode terms
  logic stby_a;
  logic stby_b;
  logic align;
  logic rise_a;
  logic rise_b;

  // straps are static by contract, so they are registered once only
  always_comb begin
    mode_d = dadc_decode({i_mode_select_first, i_mode_select_second});
    twos_d = i_output_format_select;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q <= MODE_STBY_BOTH;
      twos_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      twos_q <= twos_d;
    end
  end

  // which channels sleep, and whether b is skewed
  always_comb begin
    stby_a = 1'b0;
    stby_b = 1'b0;
    align = 1'b0;
    unique case (mode_q)
      MODE_STBY_BOTH: begin
        stby_a = 1'b1;
        stby_b = 1'b1;
      end
      MODE_STBY_B: stby_b = 1'b1;
      MODE_NORMAL: align = 1'b0;
      MODE_ALIGN: align = 1'b1;
      default: begin
        stby_a = 1'b1;
        stby_b = 1'b1;
      end
    endcase
  end

  // channel a: standby, recovery count, run
  always_comb begin
    st_a_d = dadc_next_state(st_a_q, stby_a, rise_a, cnt_a_q);
    cnt_a_d = dadc_next_count(st_a_q, stby_a, rise_a, cnt_a_q);
    en_a_d = (st_a_d != ST_IDLE);
    valid_a_d = (st_a_d == ST_RUN);
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_a_q <= ST_IDLE;
      cnt_a_q <= CNT_RESET;
      en_a_q <= 1'b0;
      valid_a_q <= 1'b0;
    end else begin
      st_a_q <= st_a_d;
      cnt_a_q <= cnt_a_d;
      en_a_q <= en_a_d;
      valid_a_q <= valid_a_d;
    end
  end

  // channel b: same walk, its own standby term
  always_comb begin
    st_b_d = dadc_next_state(st_b_q, stby_b, rise_b, cnt_b_q);
    cnt_b_d = dadc_next_count(st_b_q, stby_b, rise_b, cnt_b_q);
    en_b_d = (st_b_d != ST_IDLE);
    valid_b_d = (st_b_d == ST_RUN);
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_b_q <= ST_IDLE;
      cnt_b_q <= CNT_RESET;
      en_b_q <= 1'b0;
      valid_b_q <= 1'b0;
    end else begin
      st_b_q <= st_b_d;
      cnt_b_q <= cnt_b_d;
      en_b_q <= en_b_d;
      valid_b_q <= valid_b_d;
    end
  end

  // channel a never skews; it is the reference for aligned capture
  dadc_chan u_chan_a (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_enc(i_sample_clock_chan_a),
    .i_enable(en_a_q),
    .i_half(1'b0),
    .i_twos(twos_q),
    .i_conv(i_conv_result_chan_a),
    .o_rise(rise_a),
    .o_word(o_sample_word_chan_a)
  );

  // channel b lands on its falling edge in align mode
  dadc_chan u_chan_b (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_enc(i_sample_clock_chan_b),
    .i_enable(en_b_q),
    .i_half(align),
    .i_twos(twos_q),
    .i_conv(i_conv_result_chan_b),
    .o_rise(rise_b),
    .o_word(o_sample_word_chan_b)
  );

  // driver and clock input enables share one flop per channel
  always_comb begin
    o_sample_word_oe_chan_a = en_a_q;
    o_sample_word_oe_chan_b = en_b_q;
    o_clock_in_en_chan_a = en_a_q;
    o_clock_in_en_chan_b = en_b_q;
    o_data_valid_chan_a = valid_a_q;
    o_data_valid_chan_b = valid_b_q;
  end

  // helper: accepted a edges since leaving standby, for the recovery check
  logic [3:0] seen_a_q;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seen_a_q <= CNT_RESET;
    end else if (!o_sample_word_oe_chan_a) begin
      seen_a_q <= CNT_RESET;
    end else if (rise_a && !o_data_valid_chan_a) begin
      seen_a_q <= seen_a_q + CNT_STEP;
    end
  end

  // helper: accepted b edges since leaving standby; b can wake on its own
  logic [3:0] seen_b_q;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seen_b_q <= CNT_RESET;
    end else if (!o_sample_word_oe_chan_b) begin
      seen_b_q <= CNT_RESET;
    end else if (rise_b && !o_data_valid_chan_b) begin
      seen_b_q <= seen_b_q + CNT_STEP;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  property p_both_stby;
    (!i_mode_select_first && !i_mode_select_second)[*2]
      |=> !o_sample_word_oe_chan_a && !o_sample_word_oe_chan_b;
  endproperty
  a_both_stby: assert property (p_both_stby) else $error("drivers on in full standby");

  property p_b_stby;
    (!i_mode_select_first && i_mode_select_second)[*2]
      |=> !o_clock_in_en_chan_b && !o_sample_word_oe_chan_b && !o_data_valid_chan_b;
  endproperty
  a_b_stby: assert property (p_b_stby) else $error("channel b awake in b standby");

  property p_stby_frozen;
    !o_clock_in_en_chan_a |=> $stable(o_sample_word_chan_a);
  endproperty
  a_stby_frozen: assert property (p_stby_frozen) else $error("word moved with clock off");

  property p_recovery;
    $rose(o_data_valid_chan_a) |-> seen_a_q == RECOVERY_CYCLES;
  endproperty
  a_recovery: assert property (p_recovery) else $error("recovery edge count wrong");

  property p_recov_b;
    $rose(o_data_valid_chan_b) |-> seen_b_q == RECOVERY_CYCLES;
  endproperty
  a_recov_b: assert property (p_recov_b) else $error("b recovery edge count wrong");

  // straps reach the enables two cycles after they change
  property p_normal_wake;
    (i_mode_select_first && !i_mode_select_second)[*2]
      |=> o_sample_word_oe_chan_a && o_sample_word_oe_chan_b && o_clock_in_en_chan_b;
  endproperty
  a_normal_wake: assert property (p_normal_wake) else $error("asleep in normal");

  property p_align_sel;
    (i_mode_select_first && i_mode_select_second)[*2]
      |=> align && o_sample_word_oe_chan_b;
  endproperty
  a_align_sel: assert property (p_align_sel) else $error("b not skewed");

  property p_b_stby_a_on;
    (!i_mode_select_first && i_mode_select_second)[*2]
      |=> o_sample_word_oe_chan_a && o_clock_in_en_chan_a;
  endproperty
  a_b_stby_a_on: assert property (p_b_stby_a_on) else $error("a asleep in b standby");

  property p_frozen_b;
    !o_clock_in_en_chan_b |=> $stable(o_sample_word_chan_b);
  endproperty
  a_frozen_b: assert property (p_frozen_b) else $error("word b moved with clock off");

  // a wake always starts a fresh recovery, never a stale valid
  property p_fresh_a;
    $rose(o_sample_word_oe_chan_a) |-> !o_data_valid_chan_a;
  endproperty
  a_fresh_a: assert property (p_fresh_a) else $error("a valid at wake");

  property p_fresh_b;
    $rose(o_sample_word_oe_chan_b) |-> !o_data_valid_chan_b;
  endproperty
  a_fresh_b: assert property (p_fresh_b) else $error("b valid at wake");

  // an enabled channel must have been out of standby one cycle earlier
  property p_en_mode_a;
    o_clock_in_en_chan_a |-> !$past(stby_a);
  endproperty
  a_en_mode_a: assert property (p_en_mode_a) else $error("a on in standby");

  property p_en_mode_b;
    o_clock_in_en_chan_b |-> !$past(stby_b);
  endproperty
  a_en_mode_b: assert property (p_en_mode_b) else $error("b on in standby");

  property p_valid_on_a;
    o_data_valid_chan_a |-> o_sample_word_oe_chan_a;
  endproperty
  a_valid_on_a: assert property (p_valid_on_a) else $error("a valid while undriven");

  property p_valid_on_b;
    o_data_valid_chan_b |-> o_sample_word_oe_chan_b;
  endproperty
  a_valid_on_b: assert property (p_valid_on_b) else $error("b valid while undriven");

  c_recover_a: cover property ($rose(o_data_valid_chan_a));
  c_align_b: cover property (align && $changed(o_sample_word_chan_b));
  c_b_only: cover property (mode_q == MODE_STBY_B && o_data_valid_chan_a);
  c_recover_b: cover property ($rose(o_data_valid_chan_b));
  c_stby_both: cover property (mode_q == MODE_STBY_BOTH && $fell(o_sample_word_oe_chan_a));

endmodule : dadc_top

// ### test/dadc_far_model.sv
/*
  far-side model: one shared sample clock for both channels and the
  raw results of the analog core.
  assumes the bench system clock; everything changes at its falling edge.
*/
`timescale 1ns/100ps
module dadc_far_model (
  input wire logic i_clk_sys, // system clock
  input wire logic i_run, // sample clock toggles while high
  output logic o_clk_a, // sample clock a
  output logic o_clk_b, // sample clock b, shared with a
  output logic [7:0] o_raw_a, // raw result a
  output logic [7:0] o_raw_b, // raw result b
  output int o_count // rising edges issued so far
);
  logic [1:0] phase_q;

  initial begin
    phase_q = 2'h0;
    o_clk_a = 1'b0;
    o_raw_a = 8'h00;
    o_raw_b = 8'h00;
    o_count = 0;
  end

  // four system cycles a sample gives 2.5 MSPS; a stop parks the clock low
  always @(negedge i_clk_sys) begin
    if (!i_run) begin
      phase_q <= 2'h0;
      o_clk_a <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      o_clk_a <= (phase_q < 2'h2);
      if (phase_q == 2'h0) begin
        o_raw_a <= 8'h37 + 8'(o_count) * 8'h29;
        o_raw_b <= (8'h37 + 8'(o_count) * 8'h29) ^ 8'h5a;
        o_count <= o_count + 1;
      end
    end
  end

  // one source feeds both channels
  assign o_clk_b = o_clk_a;
endmodule : dadc_far_model

// ### test/tb_top.sv
/*
  testbench for the dual converter output stage: wake-up, recovery,
  latency, coding, align skew and both standby choices.
  assumes the far-side model file is compiled before this one.
*/
`timescale 1ns/100ps
module tb_top;
  import dadc_pkg::*;
  logic clk_sys, arst_n, run, sel1, sel2, fmt, sclk_a, sclk_b;
  logic [7:0] raw_a, raw_b, word_a, word_b, hold;
  logic oe_a, oe_b, cen_a, cen_b, val_a, val_b;
  int cnt, mismatches, samples_checked;

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  dadc_far_model far (.i_clk_sys(clk_sys), .i_run(run), .o_clk_a(sclk_a), .o_clk_b(sclk_b),
    .o_raw_a(raw_a), .o_raw_b(raw_b), .o_count(cnt));

  dadc_top dut (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_sample_clock_chan_a(sclk_a),
    .i_sample_clock_chan_b(sclk_b), .i_mode_select_first(sel1), .i_mode_select_second(sel2),
    .i_output_format_select(fmt), .i_conv_result_chan_a(raw_a), .i_conv_result_chan_b(raw_b),
    .o_sample_word_chan_a(word_a), .o_sample_word_oe_chan_a(oe_a),
    .o_sample_word_chan_b(word_b), .o_sample_word_oe_chan_b(oe_b),
    .o_clock_in_en_chan_a(cen_a), .o_clock_in_en_chan_b(cen_b),
    .o_data_valid_chan_a(val_a), .o_data_valid_chan_b(val_b));

  // expected coded word of sample k; twos complement flips the sign bit
  function automatic logic [7:0] expw(int k, bit b);
    logic [7:0] s;
    s = (8'h37 + 8'(k) * 8'h29) ^ (b ? 8'h5a : 8'h00);
    return fmt ? {~s[7], s[6:0]} : s;
  endfunction : expw

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // sample just after a falling edge, where registered outputs have settled
  task automatic step(int n);
    repeat (n) @(negedge clk_sys);
    #1;
  endtask : step

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_en(logic [3:0] exp);
    chk("enables", {4'h0, exp}, {4'h0, oe_a, oe_b, cen_a, cen_b});
  endtask : chk_en

  // bounded wait for the next sample clock rise
  task automatic wait_rise();
    int c0;
    c0 = cnt;
    for (int i = 0; i < 20 && cnt == c0; i++) step(1);
    if (cnt == c0) begin
      mismatches++;
      $display("[FAIL] sample clock stalled");
      conclude();
    end
  endtask : wait_rise

  // straps change only with the sample clock parked
  task automatic set_mode(logic [1:0] m);
    run = 1'b0;
    step(2);
    {sel1, sel2} = m;
    step(3);
    run = 1'b1;
  endtask : set_mode

  task automatic recover(logic [1:0] vpre, logic [1:0] vfin);
    for (int i = 1; i <= 15; i++) begin
      wait_rise();
      step(2);
      chk("valid", {6'h0, (i == 15) ? vfin : vpre}, {6'h0, val_a, val_b});
    end
  endtask : recover

  // captured after the output delay on the shared clock
  task automatic stream(int n, bit align, bit chb);
    int k;
    repeat (n) begin
      wait_rise();
      k = cnt - 1;
      chk("word_a early", expw(k - 5, 0), word_a);
      step(2);
      chk("word_a", expw(k - 4, 0), word_a);
      if (chb) begin
        chk("word_b", expw(k - (align ? 5 : 4), 1), word_b);
        if (align) begin
          step(2);
          chk("word_b late", expw(k - 4, 1), word_b);
        end
      end
    end
  endtask : stream

  initial begin
    arst_n = 1'b0;
    run = 1'b0;
    {sel1, sel2, fmt} = 3'h0;
    mismatches = 0;
    samples_checked = 0;
    step(2);
    chk("reset word_a", 8'h00, word_a);
    chk("reset word_b", 8'h00, word_b);
    chk_en(4'h0);
    arst_n = 1'b1;
    $display("test reset done");
    set_mode(2'h2);
    chk_en(4'hf);
    recover(2'h0, 2'h3);
    stream(6, 0, 1);
    fmt = 1'b1;
    repeat (2) wait_rise();
    stream(4, 0, 1);
    $display("test normal done");
    set_mode(2'h3);
    stream(4, 1, 1);
    $display("test align done");
    set_mode(2'h1);
    chk_en(4'ha);
    hold = word_b;
    stream(4, 0, 0);
    chk("frozen word_b", hold, word_b);
    chk("valid b off", 8'h02, {6'h0, val_a, val_b});
    set_mode(2'h2);
    recover(2'h2, 2'h3);
    stream(3, 0, 1);
    $display("test standby b done");
    set_mode(2'h0);
    chk_en(4'h0);
    hold = word_a;
    step(12);
    chk("frozen word_a", hold, word_a);
    chk("valid off", 8'h00, {6'h0, val_a, val_b});
    $display("test standby both done");
    conclude();
  end
endmodule : tb_top
